/* hdl/ppa_port_top.v */
// five 8-bit general-purpose ports: modes, pin/latch reads, alternate functions
`timescale 1ns/1ps
`default_nettype none
`include "ppa_defines.vh"

module ppa_port_top #(
  parameter NPORT = 5
) (
  input  wire              sys_clk_i,
  input  wire              sys_rst_i,
  input  wire              ce_i,
  input  wire              tristate_fuse_i,
  input  wire              power_down_i,
  input  wire              mode_wr_i,
  input  wire [7:0]        mode_wdata_i,
  input  wire              latch_wr_i,
  input  wire [2:0]        latch_sel_i,
  input  wire [7:0]        latch_wdata_i,
  input  wire              rd_i,
  input  wire              rd_rmw_i,
  input  wire [2:0]        rd_sel_i,
  input  wire              ebus_p0_en_i,
  input  wire              ebus_p0_oe_i,
  input  wire [7:0]        ebus_p0_data_i,
  input  wire              ebus_p2_en_i,
  input  wire [7:0]        ebus_p2_addr_i,
  input  wire              t0_toggle_i,
  input  wire              t1_toggle_i,
  input  wire              t2_toggle_i,
  input  wire              ser_dout_i,
  input  wire              ser_clk_out_i,
  input  wire              txd_i,
  input  wire              wr_strobe_i,
  input  wire              rd_strobe_i,
  input  wire [NPORT*8-1:0] pin_i,
  output reg  [NPORT*8-1:0] pin_o,
  output reg  [NPORT*8-1:0] pin_oe_o,
  output reg  [NPORT*8-1:0] pin_weak_up_o,
  output reg  [NPORT*8-1:0] pin_vweak_up_o,
  output reg  [7:0]        mode_o,
  output reg  [NPORT*8-1:0] latch_o,
  output reg  [7:0]        rd_data_o,
  output reg               rd_valid_o,
  output reg  [7:0]        ebus_p0_data_o,
  output reg               timer2_ext_trigger_o,
  output reg               ser_din_o,
  output reg               ser_clk_in_o,
  output reg               rxd_o,
  output reg               ext_interrupt_a_o,
  output reg               ext_interrupt_b_o,
  output reg               counter_a_input_o,
  output reg               counter_b_input_o
);

  localparam NPIN = NPORT * 8;

  reg  [NPIN-1:0] sync1_reg;
  reg  [NPIN-1:0] sync2_reg;
  reg  [NPIN-1:0] sync3_reg;
  reg  [NPIN-1:0] pin_s_reg;
  reg  [NPIN-1:0] latch_reg;
  reg  [NPIN-1:0] latch_next;
  reg  [7:0]      mode_reg;
  reg  [NPIN-1:0] alt_out;
  reg  [NPIN-1:0] sense_en;
  wire [NPIN-1:0] drive_d;
  wire [NPIN-1:0] pin_sensed;
  wire [NPIN-1:0] alt_in;
  wire [NPIN-1:0] st_out;
  wire [NPIN-1:0] st_oe;
  wire [NPIN-1:0] st_wk;
  wire [NPIN-1:0] st_vwk;
  wire [NPIN-1:0] in_only;
  integer         k;
  integer         j;
  integer         r;

  // decodes a port number into its two mode bits
  function [1:0] port_mode;
    input [7:0] mreg;
    input integer p;
    begin
      port_mode = (p < 4) ? {mreg[2*p+1], mreg[2*p]} : `PPA_MODE_QUASI;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pins are asynchronous; a level counts once the second and third stages agree
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sync1_reg <= {NPIN{1'b0}};
      sync2_reg <= {NPIN{1'b0}};
      sync3_reg <= {NPIN{1'b0}};
      pin_s_reg <= {NPIN{1'b0}};
    end else if (ce_i) begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (k = 0; k < NPIN; k = k + 1) begin
        if (sync2_reg[k] == sync3_reg[k]) begin
          pin_s_reg[k] <= sync3_reg[k];
        end
      end
    end
  end

  // the wake-up pins keep their input buffers in power-down
  always @* begin
    sense_en = {NPIN{~power_down_i}};
    sense_en[`PPA_PIN_EXT_INT_A] = 1'b1;
    sense_en[`PPA_PIN_EXT_INT_B] = 1'b1;
    sense_en[`PPA_PIN_OSC_A]     = 1'b1;
    sense_en[`PPA_PIN_OSC_B]     = 1'b1;
  end
  assign pin_sensed = pin_s_reg & sense_en;

  ////////////////////////////////////////////////////////////////////////////
  // latch update: a cpu write lands first, a timer toggle on top of it
  always @* begin
    latch_next = latch_reg;
    for (j = 0; j < NPORT; j = j + 1) begin
      if (latch_wr_i && (latch_sel_i == j[2:0])) begin
        latch_next[j*8 +: 8] = latch_wdata_i;
      end
    end
    latch_next[`PPA_PIN_T2_CLK] = latch_next[`PPA_PIN_T2_CLK] ^ t2_toggle_i;
    latch_next[`PPA_PIN_CNT_A]  = latch_next[`PPA_PIN_CNT_A] ^ t0_toggle_i;
    latch_next[`PPA_PIN_CNT_B]  = latch_next[`PPA_PIN_CNT_B] ^ t1_toggle_i;
  end

  // the fuse is sampled by the clocked reset, never wired into the flop
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_reg  <= tristate_fuse_i ? `PPA_MODE_RST_FUSE : `PPA_MODE_RST_NOFUSE;
      latch_reg <= {NPORT{`PPA_LATCH_RST}};
    end else if (ce_i) begin
      if (mode_wr_i) begin
        mode_reg <= mode_wdata_i;
      end
      latch_reg <= latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral outputs, unused pins pass the latch unchanged
  always @* begin
    alt_out = {NPIN{1'b1}};
    alt_out[`PPA_PIN_SER_DOUT] = ser_dout_i;
    alt_out[`PPA_PIN_SER_CLK]  = ser_clk_out_i;
    alt_out[`PPA_PIN_TXD]      = txd_i;
    alt_out[`PPA_PIN_WR_STB]   = wr_strobe_i;
    alt_out[`PPA_PIN_RD_STB]   = rd_strobe_i;
  end
  assign drive_d = latch_reg & alt_out;

  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1) begin : g_port
      wire       ovr_en;
      wire [7:0] ovr_oe;
      wire [7:0] ovr_d;
      assign in_only[p*8 +: 8] = {8{port_mode(mode_reg, p) == `PPA_MODE_INPUT}};
      assign ovr_en = (p == 0) ? ebus_p0_en_i : ((p == 2) ? ebus_p2_en_i : 1'b0);
      assign ovr_oe = (p == 0) ? {8{ebus_p0_oe_i}} : 8'hFF;
      assign ovr_d  = (p == 0) ? ebus_p0_data_i : ebus_p2_addr_i;
      ppa_port_stage #(
        .FORCE_QUASI (p == 4)
      ) u_stage (
        .sys_clk_i  (sys_clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .mode_i     (port_mode(mode_reg, p)),
        .latch_i    (drive_d[p*8 +: 8]),
        .pin_s_i    (pin_s_reg[p*8 +: 8]),
        .ovr_en_i   (ovr_en),
        .ovr_oe_i   (ovr_oe),
        .ovr_d_i    (ovr_d),
        .out_o      (st_out[p*8 +: 8]),
        .oe_o       (st_oe[p*8 +: 8]),
        .weak_up_o  (st_wk[p*8 +: 8]),
        .vweak_up_o (st_vwk[p*8 +: 8])
      );
    end
  endgenerate

  // in input-only mode the latch cannot mask a peripheral input
  assign alt_in = pin_sensed & (latch_reg | in_only);

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs and reads
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_o                <= {NPIN{1'b0}};
      pin_oe_o             <= {NPIN{1'b0}};
      pin_weak_up_o        <= {NPIN{1'b0}};
      pin_vweak_up_o       <= {NPIN{1'b0}};
      mode_o               <= 8'h00;
      latch_o              <= {NPORT{`PPA_LATCH_RST}};
      rd_data_o            <= 8'h00;
      rd_valid_o           <= 1'b0;
      ebus_p0_data_o       <= 8'h00;
      timer2_ext_trigger_o <= 1'b0;
      ser_din_o            <= 1'b0;
      ser_clk_in_o         <= 1'b0;
      rxd_o                <= 1'b0;
      ext_interrupt_a_o    <= 1'b0;
      ext_interrupt_b_o    <= 1'b0;
      counter_a_input_o    <= 1'b0;
      counter_b_input_o    <= 1'b0;
    end else if (ce_i) begin
      pin_o          <= st_out;
      pin_oe_o       <= st_oe;
      pin_weak_up_o  <= st_wk;
      pin_vweak_up_o <= st_vwk;
      mode_o         <= mode_reg;
      latch_o        <= latch_reg;
      rd_valid_o     <= rd_i;
      rd_data_o      <= 8'h00;
      for (r = 0; r < NPORT; r = r + 1) begin
        if (rd_i && (rd_sel_i == r[2:0])) begin
          // read-modify-write sees the latch, a plain read sees the pins
          rd_data_o <= rd_rmw_i ? latch_reg[r*8 +: 8] : pin_sensed[r*8 +: 8];
        end
      end
      ebus_p0_data_o       <= pin_sensed[7:0];
      timer2_ext_trigger_o <= alt_in[`PPA_PIN_T2_EXT];
      ser_din_o            <= alt_in[`PPA_PIN_SER_DIN];
      ser_clk_in_o         <= alt_in[`PPA_PIN_SER_CLK];
      rxd_o                <= alt_in[`PPA_PIN_RXD];
      ext_interrupt_a_o    <= alt_in[`PPA_PIN_EXT_INT_A];
      ext_interrupt_b_o    <= alt_in[`PPA_PIN_EXT_INT_B];
      counter_a_input_o    <= alt_in[`PPA_PIN_CNT_A];
      counter_b_input_o    <= alt_in[`PPA_PIN_CNT_B];
    end
  end

endmodule
`default_nettype wire

/* hdl/ppa_defines.vh */
// constants for the port pin mode and alternate-function block
`ifndef PPA_DEFINES_VH
`define PPA_DEFINES_VH

// port mode codes as {port_mode_sel_hi, port_mode_sel_lo}
`define PPA_MODE_QUASI      2'h0
`define PPA_MODE_INPUT      2'h1
`define PPA_MODE_PUSHPULL   2'h2
`define PPA_MODE_OPENDRAIN  2'h3

// mode register reset values, pairs {hi,lo} per port, port 0 in bits 1:0
`define PPA_MODE_RST_FUSE   8'h55
`define PPA_MODE_RST_NOFUSE 8'h03
`define PPA_LATCH_RST       8'hFF

// global pin index = port * 8 + bit
`define PPA_PIN_T2_CLK      8
`define PPA_PIN_T2_EXT      9
`define PPA_PIN_SER_DOUT    13
`define PPA_PIN_SER_DIN     14
`define PPA_PIN_SER_CLK     15
`define PPA_PIN_RXD         24
`define PPA_PIN_TXD         25
`define PPA_PIN_EXT_INT_A   26
`define PPA_PIN_EXT_INT_B   27
`define PPA_PIN_CNT_A       28
`define PPA_PIN_CNT_B       29
`define PPA_PIN_WR_STB      30
`define PPA_PIN_RD_STB      31
`define PPA_PIN_OSC_A       38
`define PPA_PIN_OSC_B       39

`endif

/* hdl/ppa_port_stage.v */
// output stage of one 8-bit port: drive decode per mode and bus override
`timescale 1ns/1ps
`default_nettype none
`include "ppa_defines.vh"

module ppa_port_stage #(
  parameter FORCE_QUASI = 0
) (
  input  wire       sys_clk_i,
  input  wire       sys_rst_i,
  input  wire       ce_i,
  input  wire [1:0] mode_i,
  input  wire [7:0] latch_i,
  input  wire [7:0] pin_s_i,
  input  wire       ovr_en_i,
  input  wire [7:0] ovr_oe_i,
  input  wire [7:0] ovr_d_i,
  output reg  [7:0] out_o,
  output reg  [7:0] oe_o,
  output reg  [7:0] weak_up_o,
  output reg  [7:0] vweak_up_o
);

  reg  [7:0] prev_reg;
  wire [1:0] mode_eff;
  wire [7:0] rise;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prev_reg <= `PPA_LATCH_RST;
    end else if (ce_i) begin
      prev_reg <= latch_i;
    end
  end

  assign mode_eff = (FORCE_QUASI != 0) ? `PPA_MODE_QUASI : mode_i;
  assign rise     = latch_i & ~prev_reg;

  // one mode word steers all eight pins in the same cycle
  always @* begin
    out_o      = 8'h00;
    oe_o       = 8'h00;
    weak_up_o  = 8'h00;
    vweak_up_o = 8'h00;
    case (mode_eff)
      `PPA_MODE_QUASI: begin
        out_o      = rise;
        oe_o       = ~latch_i | rise;
        weak_up_o  = latch_i & pin_s_i;
        vweak_up_o = latch_i;
      end
      `PPA_MODE_PUSHPULL: begin
        out_o = latch_i;
        oe_o  = 8'hFF;
      end
      `PPA_MODE_INPUT: begin
        oe_o = 8'h00;
      end
      `PPA_MODE_OPENDRAIN: begin
        out_o = 8'h00;
        oe_o  = ~latch_i;
      end
      default: begin
        oe_o = 8'h00;
      end
    endcase
    if (ovr_en_i) begin
      out_o      = ovr_d_i;
      oe_o       = ovr_oe_i;
      weak_up_o  = 8'h00;
      vweak_up_o = 8'h00;
    end
  end

endmodule
`default_nettype wire

/* test/ppa_pin_partner.sv */
// behavioural model of the circuits hanging on the port pins
`timescale 1ns/1ps
`default_nettype none
module ppa_pin_partner (
  input  wire logic        clk_i,
  input  wire logic [39:0] drv_i,
  input  wire logic [39:0] oe_i,
  input  wire logic [39:0] up_i,
  input  wire logic [39:0] ext_en_i,
  input  wire logic [39:0] ext_v_i,
  output wire logic [39:0] lvl_o
);
  // a floating pin wanders every cycle so no test can lean on a stale level
  logic [39:0] float_reg = 40'h0;
  always @(posedge clk_i) float_reg <= ~float_reg;
  assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_v_i)
               | (~oe_i & ~ext_en_i & (up_i | float_reg));
endmodule
`default_nettype wire

/* test/ppa_port_props.sv */
// assertion checker for the port pin block: port 1 drive and read path, port 2 bus override, port 3 mode
`timescale 1ns/1ps
`default_nettype none
`include "ppa_defines.vh"
module ppa_port_props (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        rd_i,
  input wire logic        rd_rmw_i,
  input wire logic [2:0]  rd_sel_i,
  input wire logic        ebus_p2_en_i,
  input wire logic [39:0] pin_o,
  input wire logic [39:0] pin_oe_o,
  input wire logic [39:0] pin_weak_up_o,
  input wire logic [39:0] pin_vweak_up_o,
  input wire logic [7:0]  mode_o,
  input wire logic [39:0] latch_o,
  input wire logic [7:0]  rd_data_o,
  input wire logic        rd_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_input_tristate: assert property (mode_o[3:2] == `PPA_MODE_INPUT |->
    pin_oe_o[15:8] == 8'h00 && (pin_weak_up_o[15:8] | pin_vweak_up_o[15:8]) == 8'h00)
    else $error("input-only port still drives");
  a_open_drain: assert property (mode_o[3:2] == `PPA_MODE_OPENDRAIN |->
    pin_oe_o[15:8] == ~latch_o[15:8] && (pin_o[15:8] & pin_oe_o[15:8]) == 8'h00
    && (pin_weak_up_o[15:8] | pin_vweak_up_o[15:8]) == 8'h00) else $error("open-drain drive");
  a_push_pull: assert property (mode_o[3:2] == `PPA_MODE_PUSHPULL |->
    pin_oe_o[15:8] == 8'hFF && pin_o[15:8] == latch_o[15:8]) else $error("push-pull drive");
  a_quasi_pulse: assert property (mode_o[3:2] == `PPA_MODE_QUASI &&
    $past(mode_o[3:2]) == `PPA_MODE_QUASI && $rose(latch_o[9]) |-> pin_oe_o[9] && pin_o[9]
    ##1 (!pin_oe_o[9] || !latch_o[9] || mode_o[3:2] != `PPA_MODE_QUASI))
    else $error("strong pull-up pulse wrong");
  a_read_valid: assert property (rd_i |=> rd_valid_o) else $error("read not answered");
  a_read_latch: assert property (rd_i && rd_rmw_i && rd_sel_i == 3'h1 |=>
    rd_data_o == latch_o[15:8]) else $error("latch read wrong");
  a_sel_refused: assert property (rd_i && rd_sel_i > 3'h4 |=> rd_data_o == 8'h00)
    else $error("bad port read not zero");
  a_port3_mode: assert property (mode_o[7:6] == `PPA_MODE_PUSHPULL |->
    pin_oe_o[31:24] == 8'hFF) else $error("port 3 mode ignored");
  a_bus_upper: assert property (ebus_p2_en_i [*4] |-> pin_oe_o[23:16] == 8'hFF &&
    (pin_weak_up_o[23:16] | pin_vweak_up_o[23:16]) == 8'h00) else $error("port 2 not output");
endmodule
bind ppa_port_top ppa_port_props chk_u (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .rd_i(rd_i), .rd_rmw_i(rd_rmw_i),
  .rd_sel_i(rd_sel_i), .ebus_p2_en_i(ebus_p2_en_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .pin_weak_up_o(pin_weak_up_o), .pin_vweak_up_o(pin_vweak_up_o), .mode_o(mode_o),
  .latch_o(latch_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
`default_nettype wire

/* test/tb_ppa_port_top.sv */
// self-checking bench for the port pin block
`timescale 1ns/1ps
`default_nettype none
`include "ppa_defines.vh"
module tb_ppa_port_top;
  typedef struct packed {logic [1:0] m; logic [7:0] l, oe, od, vw;} ppa_row_t;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        fuse_s, pdn_s, mwr_s, lwr_s, rd_s, rmw_s, txd_s, rv_s, p0_en_s, p0_oe_s, p2_en_s;
  logic [2:0]  lsel_s, rsel_s, tog_s;
  logic [7:0]  mdat_s, ldat_s, p0_d_s, p2_a_s, mode_s, rdat_s, p0_q_s, alt_s;
  logic [39:0] ext_en_s, ext_v_s, lvl_s, po_s, oe_s, wu_s, vwu_s, lat_s;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          tp [3] = '{`PPA_PIN_CNT_A, `PPA_PIN_CNT_B, `PPA_PIN_T2_CLK};
  ppa_row_t    rows [8] = '{
    '{`PPA_MODE_QUASI, 8'hA5, 8'h5A, 8'h00, 8'hA5}, '{`PPA_MODE_QUASI, 8'h5A, 8'hA5, 8'h00, 8'h5A},
    '{`PPA_MODE_INPUT, 8'hA5, 8'h00, 8'h00, 8'h00}, '{`PPA_MODE_INPUT, 8'h5A, 8'h00, 8'h00, 8'h00},
    '{`PPA_MODE_PUSHPULL, 8'hA5, 8'hFF, 8'hA5, 8'h00},
    '{`PPA_MODE_PUSHPULL, 8'h5A, 8'hFF, 8'h5A, 8'h00},
    '{`PPA_MODE_OPENDRAIN, 8'hA5, 8'h5A, 8'h00, 8'h00},
    '{`PPA_MODE_OPENDRAIN, 8'h5A, 8'hA5, 8'h00, 8'h00}};
  ppa_port_top dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .tristate_fuse_i(fuse_s), .power_down_i(pdn_s), .mode_wr_i(mwr_s), .mode_wdata_i(mdat_s),
    .latch_wr_i(lwr_s), .latch_sel_i(lsel_s), .latch_wdata_i(ldat_s), .rd_i(rd_s),
    .rd_rmw_i(rmw_s), .rd_sel_i(rsel_s), .ebus_p0_en_i(p0_en_s), .ebus_p0_oe_i(p0_oe_s),
    .ebus_p0_data_i(p0_d_s), .ebus_p2_en_i(p2_en_s), .ebus_p2_addr_i(p2_a_s),
    .t0_toggle_i(tog_s[0]), .t1_toggle_i(tog_s[1]), .t2_toggle_i(tog_s[2]), .ser_dout_i(1'b1),
    .ser_clk_out_i(1'b1), .txd_i(txd_s), .wr_strobe_i(1'b1), .rd_strobe_i(1'b1), .pin_i(lvl_s),
    .pin_o(po_s), .pin_oe_o(oe_s), .pin_weak_up_o(wu_s), .pin_vweak_up_o(vwu_s), .mode_o(mode_s),
    .latch_o(lat_s), .rd_data_o(rdat_s), .rd_valid_o(rv_s), .ebus_p0_data_o(p0_q_s),
    .timer2_ext_trigger_o(alt_s[0]), .ser_din_o(alt_s[1]), .ser_clk_in_o(alt_s[2]),
    .rxd_o(alt_s[3]), .ext_interrupt_a_o(alt_s[4]), .ext_interrupt_b_o(alt_s[5]),
    .counter_a_input_o(alt_s[6]), .counter_b_input_o(alt_s[7]));
  ppa_pin_partner ext_u (.clk_i(sys_clk_i), .drv_i(po_s), .oe_i(oe_s), .up_i(wu_s | vwu_s),
    .ext_en_i(ext_en_s), .ext_v_i(ext_v_s), .lvl_o(lvl_s));
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic is_mode, input logic [2:0] sel, input logic [7:0] dat);
    @(negedge sys_clk_i);
    {mwr_s, lwr_s, lsel_s, mdat_s, ldat_s} = {is_mode, !is_mode, sel, dat, dat};
    @(negedge sys_clk_i);
    {mwr_s, lwr_s} = 2'b00;
  endtask
  task automatic rd_port(input logic rmw, input logic [2:0] sel, input logic [7:0] exp);
    @(negedge sys_clk_i);
    {rd_s, rmw_s, rsel_s} = {1'b1, rmw, sel};
    @(negedge sys_clk_i);
    // the answer stands for one cycle only, so look before the next edge
    chk(rv_s, 1'b1);
    chk(rdat_s, exp);
    rd_s = 1'b0;
  endtask
  task automatic reset_dut(input logic fuse);
    {fuse_s, sys_rst_i} = {fuse, 1'b1};
    waitn(20);
    sys_rst_i = 1'b0;
    waitn(4);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {pdn_s, mwr_s, lwr_s, rd_s, rmw_s, txd_s, p0_en_s, p0_oe_s, p2_en_s, tog_s} = '0;
    {lsel_s, rsel_s, mdat_s, ldat_s, p0_d_s, p2_a_s, ext_en_s, ext_v_s} = '0;
    reset_dut(1'b0);
    chk(mode_s, `PPA_MODE_RST_NOFUSE);
    chk(lat_s, {5{`PPA_LATCH_RST}});
    foreach (rows[i]) begin
      wr(1'b1, 3'h0, {4'h0, rows[i].m, 2'h0});
      wr(1'b0, 3'h1, rows[i].l);
      waitn(4);
      chk(oe_s[15:8], rows[i].oe);
      chk(po_s[15:8] & oe_s[15:8], rows[i].od);
      chk(vwu_s[15:8], rows[i].vw);
    end
    // quasi weak pull-up follows latch and pin: low half pulled down outside
    wr(1'b1, 3'h0, 8'h00);
    wr(1'b0, 3'h1, 8'hFF);
    {ext_en_s[15:8], ext_v_s[15:8]} = {8'h0F, 8'h00};
    waitn(8);
    chk(wu_s[15:8], 8'hF0);
    chk(vwu_s[15:8], 8'hFF);
    // pins differ from latch so the two read paths cannot be confused
    wr(1'b1, 3'h0, 8'h04);
    wr(1'b0, 3'h1, 8'hA5);
    {ext_en_s[15:8], ext_v_s[15:8]} = {8'hFF, 8'h3C};
    waitn(8);
    rd_port(1'b0, 3'h1, 8'h3C);
    rd_port(1'b1, 3'h1, 8'hA5);
    rd_port(1'b0, 3'h5, 8'h00);
    {ext_en_s, ext_v_s} = {40'h00_FF00_FF00, 40'h00_2C00_8200};
    // port 1 goes back to quasi: it carries peripheral inputs and outputs at once
    wr(1'b1, 3'h0, 8'h40);
    wr(1'b0, 3'h3, 8'h00);
    waitn(8);
    chk(alt_s[7], 1'b1);
    chk(alt_s, 8'hB4);
    pdn_s = 1'b1;
    waitn(8);
    chk(alt_s[7], 1'b0);
    chk(alt_s, 8'h30);
    chk(alt_s[4], 1'b1);
    {pdn_s, ext_en_s} = '0;
    wr(1'b1, 3'h0, 8'h88);
    wr(1'b0, 3'h3, 8'hFF);
    wr(1'b0, 3'h1, 8'hFF);
    waitn(4);
    chk(po_s[25], 1'b0);
    txd_s = 1'b1;
    waitn(4);
    chk(po_s[25], 1'b1);
    wr(1'b0, 3'h3, 8'hFD);
    waitn(4);
    chk(po_s[25], 1'b0);
    foreach (tp[i]) begin
      tog_s[i] = 1'b1;
      waitn(1);
      tog_s[i] = 1'b0;
      waitn(3);
      chk(lat_s[tp[i]], 1'b0);
      chk(po_s[tp[i]], 1'b0);
    end
    wr(1'b1, 3'h0, 8'h11);
    {p2_en_s, p2_a_s, p0_en_s, p0_oe_s, p0_d_s} = {1'b1, 8'hC3, 1'b1, 1'b1, 8'h96};
    waitn(6);
    chk(oe_s[23:16], 8'hFF);
    chk(po_s[23:16], 8'hC3);
    chk({oe_s[7:0], po_s[7:0]}, 16'hFF96);
    p0_oe_s = 1'b0;
    {ext_en_s[7:0], ext_v_s[7:0]} = {8'hFF, 8'h69};
    waitn(8);
    chk(oe_s[7:0], 8'h00);
    chk(p0_q_s, 8'h69);
    {p0_en_s, p2_en_s, ext_en_s} = '0;
    reset_dut(1'b1);
    chk(mode_s, `PPA_MODE_RST_FUSE);
    chk(oe_s, 40'h0);
    chk(vwu_s[39:32], 8'hFF);
    chk(vwu_s[31:0], 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
